// ### core/pts_pkg.sv
// How it works
// - Command nibble 0000 is a control step; the option nibble picks its action.
// - Nibble 0001 adds adjust value when option MSB is 0, copies hold value when 1.
// - Pattern 001x writes {cmd0,option} into the five low ADC channel bits.
// - Nibble 0100 stalls until a rising edge on the selected trigger input.
// - Nibble 0101 stalls until a falling edge on the selected trigger input.
// - Reserved commands and options are consumed but change nothing.
// - Nibble 0111 pulses interrupt request 0..3 by option; options 4..15 reserved.
// - Pattern 100x pulses exactly one of 32 trigger outputs, indexed by {cmd0,option}.
// - Pattern 110x: at loop limit A advance, else bump counter A and jump.
// - Pattern 111x: at loop limit B advance, else bump counter B and jump.
// - Control option 0010 disables the step delay timer, 0110 enables it.
// - Control options 1000/1001 run timer A/B until it matches its limit.
// - Control option 1011 holds until the software trigger bit goes 0 to 1.
// - Control options 1100/1101/1110 copy counter A, counter B, literal to ADC select.
// - Control option 1111 pulses every trigger enabled in the broadcast register.
// - Add targets by option 0..5: loop A, loop B, timer A, timer B, delay, literal.
// - Copy targets by option 8..13 in the same order; 14 and 15 reserved.
// - Edge-wait inputs map peripheral events by option; codes 0101, 0110 reserved.
// - Trigger outputs route to compare, capture, ADC, PWM, comparator and pin map.
// - With step delay enabled each step that does not wait lasts step delay limit plus one clocks.
// - A 5-bit queue pointer selects one of 32 step bytes; bytes 0..15 sit two per queue word in the 8 queue words.
// - While enabled and started, limits, hold, adjust, literal, pointer, queue are read-only.
`default_nettype none

package pts_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned QPTR_W = 5;
    localparam int unsigned NUM_STEPS = 32;
    localparam int unsigned NUM_QWORDS = 8;
    localparam int unsigned NUM_LIM = 6;
    localparam int unsigned NUM_TRIG = 32;
    localparam int unsigned NUM_TIN = 16;
    localparam int unsigned NUM_IRQ = 4;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BTE = 8'h04;
    localparam logic [7:0] ADDR_LIM0 = 8'h08;
    localparam logic [7:0] ADDR_HOLD = 8'h20;
    localparam logic [7:0] ADDR_ADJ = 8'h24;
    localparam logic [7:0] ADDR_QPTR = 8'h28;
    localparam logic [7:0] ADDR_CNTA = 8'h2c;
    localparam logic [7:0] ADDR_CNTB = 8'h30;
    localparam logic [7:0] ADDR_ADCSEL = 8'h34;
    localparam logic [7:0] ADDR_QUE0 = 8'h38;
    localparam logic [7:0] ADDR_QUE_LAST = 8'h54;

    // Control register fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 1;
    localparam int unsigned CTRL_SWT_BIT = 2;
    localparam int unsigned CTRL_SDEN_BIT = 3;
    localparam int unsigned CTRL_STATE_LSB = 4;

    // Index into the adjustable value array, in add/copy target order
    localparam logic [2:0] LIM_LOOP_A = 3'd0;
    localparam logic [2:0] LIM_LOOP_B = 3'd1;
    localparam logic [2:0] LIM_TMR_A = 3'd2;
    localparam logic [2:0] LIM_TMR_B = 3'd3;
    localparam logic [2:0] LIM_SDLY = 3'd4;
    localparam logic [2:0] LIM_LIT = 3'd5;

    // Command nibbles and three-bit prefixes
    localparam logic [3:0] CMD_CTRL = 4'h0;
    localparam logic [3:0] CMD_ADDCOPY = 4'h1;
    localparam logic [3:0] CMD_WAIT_RISE = 4'h4;
    localparam logic [3:0] CMD_WAIT_FALL = 4'h5;
    localparam logic [3:0] CMD_IRQ = 4'h7;
    localparam logic [2:0] PFX_STROBE = 3'h1;
    localparam logic [2:0] PFX_TRIG = 3'h4;
    localparam logic [2:0] PFX_JUMP = 3'h5;
    localparam logic [2:0] PFX_LOOP_A = 3'h6;
    localparam logic [2:0] PFX_LOOP_B = 3'h7;

    // Control step options, reserved edge-wait options and the highest interrupt option
    localparam logic [3:0] OPT_SD_OFF = 4'h2;
    localparam logic [3:0] OPT_SD_ON = 4'h6;
    localparam logic [3:0] OPT_TMR_A = 4'h8;
    localparam logic [3:0] OPT_TMR_B = 4'h9;
    localparam logic [3:0] OPT_SWT = 4'hb;
    localparam logic [3:0] OPT_ADC_CNTA = 4'hc;
    localparam logic [3:0] OPT_ADC_CNTB = 4'hd;
    localparam logic [3:0] OPT_ADC_LIT = 4'he;
    localparam logic [3:0] OPT_BCAST = 4'hf;
    localparam logic [3:0] OPT_WAIT_RSV0 = 4'h5;
    localparam logic [3:0] OPT_WAIT_RSV1 = 4'h6;
    localparam logic [3:0] OPT_IRQ_MAX = 4'h3;

    // Reset values
    localparam logic [15:0] RST_DATA = 16'h0000;
    localparam logic [31:0] RST_BTE = 32'h0000_0000;
    localparam logic [4:0] RST_QPTR = 5'h00;

    typedef enum logic [1:0] {
        PTS_IDLE = 2'b00,
        PTS_EXEC = 2'b01,
        PTS_WAIT = 2'b11,
        PTS_DELAY = 2'b10
    } pts_state_t;

endpackage : pts_pkg

`default_nettype wire

// ### core/pts_step_sequencer.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module pts_step_sequencer #(
    parameter int unsigned NUM_TIN = pts_pkg::NUM_TIN
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_TIN-1:0] trig_in,
    output logic [31:0] trig_out,
    output logic [3:0] irq_out,
    output logic [15:0] adc_chan_sel,
    output logic adc_chan_sel_wr
);

    // Bus side
    logic pready_q, pslverr_q, addr_ok, setup, wr_fire;
    logic [31:0] prdata_q, rd_data;
    logic [7:0] lim_off, que_off;
    logic [2:0] li, qi;

    // Software visible state
    logic ctrl_en_q, ctrl_start_q, ctrl_swt_q, swt_prev_q, sd_en_q, adc_wr_q;
    logic [31:0] bte_q, trig_q;
    logic [15:0] lim_q [pts_pkg::NUM_LIM];
    logic [15:0] hold_q, adj_q, cnt_a_q, cnt_b_q, adc_sel_q;
    logic [4:0] qptr_q, qptr_d;
    logic [7:0] step_mem [pts_pkg::NUM_STEPS];
    logic [3:0] irq_q;

    // Engine
    pts_pkg::pts_state_t state_q, state_d;
    logic run, exec_now, is_wait, wait_hit, step_done, jump_take;
    logic [7:0] step;
    logic [3:0] cmd, opt;
    logic [4:0] tgt;
    logic [15:0] tmr_q, dly_q;

    // Input conditioning
    logic [NUM_TIN-1:0] tin_s1_q, tin_s2_q, tin_s3_q, tin_lvl_q, tin_prev_q;
    logic [NUM_TIN-1:0] tin_rise, tin_fall;

    function automatic logic [4:0] step_target(input logic [3:0] c, input logic [3:0] o);
        step_target = {c[0], o};
    endfunction : step_target

    function automatic logic opt_is_wait_ctrl(input logic [3:0] o);
        opt_is_wait_ctrl = (o == pts_pkg::OPT_TMR_A) || (o == pts_pkg::OPT_TMR_B) ||
                           (o == pts_pkg::OPT_SWT);
    endfunction : opt_is_wait_ctrl

    assign setup = psel & ~penable;
    assign wr_fire = psel & penable & pwrite & pready_q;
    assign lim_off = paddr - pts_pkg::ADDR_LIM0;
    assign que_off = paddr - pts_pkg::ADDR_QUE0;
    assign li = lim_off[4:2];
    assign qi = que_off[4:2];

    assign run = ctrl_en_q & ctrl_start_q;
    assign exec_now = run && (state_q == pts_pkg::PTS_EXEC);
    assign step = step_mem[qptr_q];
    assign cmd = step[7:4];
    assign opt = step[3:0];
    assign tgt = step_target(cmd, opt);

    assign tin_rise = tin_lvl_q & ~tin_prev_q;
    assign tin_fall = ~tin_lvl_q & tin_prev_q;

    // Peripheral events from other clocks; a level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tin_s1_q <= '0;
            tin_s2_q <= '0;
            tin_s3_q <= '0;
            tin_lvl_q <= '0;
            tin_prev_q <= '0;
        end else begin
            tin_s1_q <= trig_in;
            tin_s2_q <= tin_s1_q;
            tin_s3_q <= tin_s2_q;
            tin_lvl_q <= (tin_s2_q & tin_s3_q) | (tin_lvl_q & (tin_s2_q | tin_s3_q));
            tin_prev_q <= tin_lvl_q;
        end
    end

    // Read mux and address decode
    always_comb begin
        rd_data = '0;
        addr_ok = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            addr_ok = 1'b0;
        end else if (paddr >= pts_pkg::ADDR_QUE0 && paddr <= pts_pkg::ADDR_QUE_LAST) begin
            rd_data = {16'h0000, step_mem[{qi, 1'b1}], step_mem[{qi, 1'b0}]};
        end else if (paddr >= pts_pkg::ADDR_LIM0 && paddr < pts_pkg::ADDR_HOLD) begin
            rd_data = {16'h0000, lim_q[li]};
        end else begin
            case (paddr)
                pts_pkg::ADDR_CTRL: begin
                    rd_data[pts_pkg::CTRL_EN_BIT] = ctrl_en_q;
                    rd_data[pts_pkg::CTRL_START_BIT] = ctrl_start_q;
                    rd_data[pts_pkg::CTRL_SWT_BIT] = ctrl_swt_q;
                    rd_data[pts_pkg::CTRL_SDEN_BIT] = sd_en_q;
                    rd_data[pts_pkg::CTRL_STATE_LSB +: 2] = state_q;
                end
                pts_pkg::ADDR_BTE: rd_data = bte_q;
                pts_pkg::ADDR_HOLD: rd_data = {16'h0000, hold_q};
                pts_pkg::ADDR_ADJ: rd_data = {16'h0000, adj_q};
                pts_pkg::ADDR_QPTR: rd_data = {27'h0000000, qptr_q};
                pts_pkg::ADDR_CNTA: rd_data = {16'h0000, cnt_a_q};
                pts_pkg::ADDR_CNTB: rd_data = {16'h0000, cnt_b_q};
                pts_pkg::ADDR_ADCSEL: rd_data = {16'h0000, adc_sel_q};
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // No wait state: the answer is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            // Error stands only with ready, never into the next transfer
            pslverr_q <= setup & ~addr_ok;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // Control bits stay writable while running so software can stop or trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_q <= 1'b0;
            ctrl_start_q <= 1'b0;
            ctrl_swt_q <= 1'b0;
            swt_prev_q <= 1'b0;
        end else begin
            swt_prev_q <= ctrl_swt_q;
            if (wr_fire && paddr == pts_pkg::ADDR_CTRL) begin
                ctrl_en_q <= pwdata[pts_pkg::CTRL_EN_BIT];
                ctrl_start_q <= pwdata[pts_pkg::CTRL_START_BIT];
                ctrl_swt_q <= pwdata[pts_pkg::CTRL_SWT_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_en_q <= 1'b0;
        end else if (exec_now && cmd == pts_pkg::CMD_CTRL) begin
            if (opt == pts_pkg::OPT_SD_OFF) begin
                sd_en_q <= 1'b0;
            end else if (opt == pts_pkg::OPT_SD_ON) begin
                sd_en_q <= 1'b1;
            end
        end
    end

    // Data registers are locked against software while the engine runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bte_q <= pts_pkg::RST_BTE;
            hold_q <= pts_pkg::RST_DATA;
            adj_q <= pts_pkg::RST_DATA;
        end else if (wr_fire && !run) begin
            if (paddr == pts_pkg::ADDR_BTE) begin
                bte_q <= pwdata;
            end
            if (paddr == pts_pkg::ADDR_HOLD) begin
                hold_q <= pwdata[15:0];
            end
            if (paddr == pts_pkg::ADDR_ADJ) begin
                adj_q <= pwdata[15:0];
            end
        end
    end

    // Limits and literal: written by software when idle, by add/copy steps when running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < pts_pkg::NUM_LIM; i++) begin
                lim_q[i] <= pts_pkg::RST_DATA;
            end
        end else begin
            for (int i = 0; i < pts_pkg::NUM_LIM; i++) begin
                if (wr_fire && !run && paddr[1:0] == 2'b00 && paddr >= pts_pkg::ADDR_LIM0 &&
                    paddr < pts_pkg::ADDR_HOLD && li == 3'(i)) begin
                    lim_q[i] <= pwdata[15:0];
                end else if (exec_now && cmd == pts_pkg::CMD_ADDCOPY && opt[2:0] == 3'(i)) begin
                    // Option 6 and 7 in either half match no entry and do nothing
                    lim_q[i] <= opt[3] ? hold_q : lim_q[i] + adj_q;
                end
            end
        end
    end

    // Step bytes survive every reset, so this array has none
    always_ff @(posedge pclk) begin
        if (wr_fire && !run && paddr >= pts_pkg::ADDR_QUE0 &&
            paddr <= pts_pkg::ADDR_QUE_LAST && paddr[1:0] == 2'b00) begin
            step_mem[{qi, 1'b1}] <= pwdata[15:8];
            step_mem[{qi, 1'b0}] <= pwdata[7:0];
        end
    end

    // Wait completion and jump decision
    always_comb begin
        is_wait = 1'b0;
        wait_hit = 1'b0;
        case (cmd)
            pts_pkg::CMD_WAIT_RISE: begin
                is_wait = (opt != pts_pkg::OPT_WAIT_RSV0) && (opt != pts_pkg::OPT_WAIT_RSV1);
                wait_hit = tin_rise[opt];
            end
            pts_pkg::CMD_WAIT_FALL: begin
                is_wait = (opt != pts_pkg::OPT_WAIT_RSV0) && (opt != pts_pkg::OPT_WAIT_RSV1);
                wait_hit = tin_fall[opt];
            end
            pts_pkg::CMD_CTRL: begin
                is_wait = opt_is_wait_ctrl(opt);
                if (opt == pts_pkg::OPT_TMR_A) begin
                    wait_hit = (tmr_q == lim_q[pts_pkg::LIM_TMR_A]);
                end else if (opt == pts_pkg::OPT_TMR_B) begin
                    wait_hit = (tmr_q == lim_q[pts_pkg::LIM_TMR_B]);
                end else begin
                    wait_hit = ctrl_swt_q & ~swt_prev_q;
                end
            end
            default: wait_hit = 1'b0;
        endcase
        jump_take = (cmd[3:1] == pts_pkg::PFX_JUMP) ||
                    (cmd[3:1] == pts_pkg::PFX_LOOP_A && cnt_a_q != lim_q[pts_pkg::LIM_LOOP_A]) ||
                    (cmd[3:1] == pts_pkg::PFX_LOOP_B && cnt_b_q != lim_q[pts_pkg::LIM_LOOP_B]);
    end

    // Sequencing
    always_comb begin
        state_d = state_q;
        qptr_d = qptr_q;
        step_done = 1'b0;
        case (state_q)
            pts_pkg::PTS_IDLE: state_d = pts_pkg::PTS_EXEC;
            pts_pkg::PTS_EXEC: begin
                if (is_wait) begin
                    state_d = pts_pkg::PTS_WAIT;
                end else begin
                    step_done = 1'b1;
                end
            end
            pts_pkg::PTS_WAIT: step_done = wait_hit;
            pts_pkg::PTS_DELAY: begin
                if (dly_q == lim_q[pts_pkg::LIM_SDLY]) begin
                    state_d = pts_pkg::PTS_EXEC;
                end
            end
            default: state_d = pts_pkg::PTS_IDLE;
        endcase
        if (step_done) begin
            if (state_q == pts_pkg::PTS_EXEC && jump_take) begin
                qptr_d = tgt;
            end else begin
                qptr_d = qptr_q + 5'd1;
            end
            // Delay of limit plus one: the execute cycle plus limit delay cycles
            if (sd_en_q && lim_q[pts_pkg::LIM_SDLY] != 16'h0000) begin
                state_d = pts_pkg::PTS_DELAY;
            end else begin
                state_d = pts_pkg::PTS_EXEC;
            end
        end
        if (!run) begin
            state_d = pts_pkg::PTS_IDLE;
            qptr_d = qptr_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pts_pkg::PTS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qptr_q <= pts_pkg::RST_QPTR;
        end else if (!run) begin
            if (wr_fire && paddr == pts_pkg::ADDR_QPTR) begin
                qptr_q <= pwdata[4:0];
            end
        end else begin
            qptr_q <= qptr_d;
        end
    end

    // Internal timer restarts on every execute and counts while waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_q <= pts_pkg::RST_DATA;
            dly_q <= pts_pkg::RST_DATA;
        end else begin
            if (state_q == pts_pkg::PTS_WAIT) begin
                tmr_q <= tmr_q + 16'h0001;
            end else begin
                tmr_q <= pts_pkg::RST_DATA;
            end
            if (state_q == pts_pkg::PTS_DELAY) begin
                dly_q <= dly_q + 16'h0001;
            end else begin
                dly_q <= 16'h0001;
            end
        end
    end

    // Loop counters clear while the sequencer is disabled so loops restart cleanly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a_q <= pts_pkg::RST_DATA;
            cnt_b_q <= pts_pkg::RST_DATA;
        end else if (!ctrl_en_q) begin
            cnt_a_q <= pts_pkg::RST_DATA;
            cnt_b_q <= pts_pkg::RST_DATA;
        end else if (exec_now) begin
            if (cmd[3:1] == pts_pkg::PFX_LOOP_A) begin
                cnt_a_q <= jump_take ? cnt_a_q + 16'h0001 : pts_pkg::RST_DATA;
            end
            if (cmd[3:1] == pts_pkg::PFX_LOOP_B) begin
                cnt_b_q <= jump_take ? cnt_b_q + 16'h0001 : pts_pkg::RST_DATA;
            end
        end
    end

    // ADC channel select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_sel_q <= pts_pkg::RST_DATA;
            adc_wr_q <= 1'b0;
        end else begin
            adc_wr_q <= 1'b0;
            if (exec_now && cmd[3:1] == pts_pkg::PFX_STROBE) begin
                adc_sel_q[4:0] <= tgt;
                adc_wr_q <= 1'b1;
            end else if (exec_now && cmd == pts_pkg::CMD_CTRL) begin
                if (opt == pts_pkg::OPT_ADC_CNTA) begin
                    adc_sel_q <= cnt_a_q;
                    adc_wr_q <= 1'b1;
                end else if (opt == pts_pkg::OPT_ADC_CNTB) begin
                    adc_sel_q <= cnt_b_q;
                    adc_wr_q <= 1'b1;
                end else if (opt == pts_pkg::OPT_ADC_LIT) begin
                    adc_sel_q <= lim_q[pts_pkg::LIM_LIT];
                    adc_wr_q <= 1'b1;
                end
            end
        end
    end

    // Trigger and interrupt pulses last one clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= '0;
            irq_q <= '0;
        end else begin
            trig_q <= '0;
            irq_q <= '0;
            if (exec_now && cmd[3:1] == pts_pkg::PFX_TRIG) begin
                trig_q <= 32'h0000_0001 << tgt;
            end else if (exec_now && cmd == pts_pkg::CMD_CTRL && opt == pts_pkg::OPT_BCAST) begin
                trig_q <= bte_q;
            end
            if (exec_now && cmd == pts_pkg::CMD_IRQ && opt <= pts_pkg::OPT_IRQ_MAX) begin
                irq_q[opt[1:0]] <= 1'b1;
            end
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign trig_out = trig_q;
    assign irq_out = irq_q;
    assign adc_chan_sel = adc_sel_q;
    assign adc_chan_sel_wr = adc_wr_q;

endmodule : pts_step_sequencer

`default_nettype wire

// ### tb/pts_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pts_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] trig_out,
    input wire logic [3:0] irq_out,
    input wire logic [15:0] adc_chan_sel,
    input wire logic adc_chan_sel_wr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wdone;
        psel && penable && pready && pwrite;
    endsequence
    a_ready_next: assert property (s_setup |=> pready) else $error("ready late");
    a_ready_once: assert property (pready |=> !pready) else $error("ready held");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("no error");
    a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
    a_wr_rdata: assert property (s_wdone |-> prdata == 32'h0) else $error("write data out");
    a_irq_single: assert property ($onehot0(irq_out)) else $error("two irqs");
    a_irq_pulse: assert property ((irq_out & $past(irq_out)) == 4'h0) else $error("irq held");
    a_trig_pulse: assert property ((trig_out & $past(trig_out)) == 32'h0) else $error("trig held");
    a_adc_by_step: assert property ($changed(adc_chan_sel) |-> adc_chan_sel_wr)
        else $error("adc select moved");
endmodule : pts_sva
bind pts_step_sequencer pts_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .trig_out, .irq_out, .adc_chan_sel, .adc_chan_sel_wr);
`default_nettype wire

// ### tb/pts_periph.sv
`timescale 1ns/100ps
`default_nettype none
module pts_periph (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] ev_idx,
    input wire logic ev_go,
    output logic [15:0] trig_in
);
    // Event lines idle low; each strobe flips one line, giving rising and falling edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_in <= 16'h0000;
        end else if (ev_go) begin
            trig_in[ev_idx] <= ~trig_in[ev_idx];
        end
    end
endmodule : pts_periph
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ev_go = 0;
    logic pready, pslverr, adc_chan_sel_wr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, trig_out, rd;
    logic [3:0] irq_out, ev_idx = 4'h0;
    logic [15:0] trig_in, adc_chan_sel;
    logic [15:0] alog[$];
    int n_fail = 0, checks_done = 0, cyc = 0;
    int tc[32], tl[32];
    int ic[4];
    localparam logic [15:0] PROG[8] = '{16'h9f85, 16'h7370, 16'h3a60, 16'h150f,
        16'h810e, 16'h4ec9, 16'h8206, 16'haf83};
    localparam logic [7:0] CFG_A[5] = '{8'h04, 8'h08, 8'h1c, 8'h24, 8'h18};
    localparam logic [31:0] CFG_D[5] = '{32'h300, 32'h2, 32'h100, 32'h23, 32'h4};
    localparam logic [15:0] PROG2[5] = '{16'h1a02, 16'h0886, 16'h5e87, 16'h840b, 16'ha9e7};
    always #10 pclk = ~pclk;
    pts_step_sequencer DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .trig_in, .trig_out, .irq_out, .adc_chan_sel,
        .adc_chan_sel_wr);
    pts_periph PER (.pclk, .presetn, .ev_idx, .ev_go, .trig_in);
    always @(posedge pclk) begin
        cyc++;
        for (int i = 0; i < 32; i++) if (trig_out[i] === 1'b1) tc[i]++;
        for (int i = 0; i < 32; i++) if (trig_out[i] === 1'b1) tl[i] = cyc;
        for (int i = 0; i < 4; i++) if (irq_out[i] === 1'b1) ic[i]++;
        if (adc_chan_sel_wr === 1'b1) alog.push_back(adc_chan_sel);
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Entered just after an edge; the idle cycle at the end keeps psel from toggling twice
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : bus
    task automatic t_regs;
        bus(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h5c, 32'h0);
        chk({31'h0, er}, 32'h1);
        bus(1'b1, 8'h09, 32'h5);
        chk({31'h0, er}, 32'h1);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h0);
        bus(1'b1, 8'h2c, 32'h7);
        bus(1'b0, 8'h2c, 32'h0);
        chk(rd, 32'h0);
    endtask : t_regs
    task automatic t_load;
        for (int i = 0; i < 8; i++) bus(1'b1, 8'(8'h38 + 4 * i), {16'h0, PROG[i]});
        for (int i = 0; i < 5; i++) bus(1'b1, CFG_A[i], CFG_D[i]);
    endtask : t_load
    task automatic t_run;
        bus(1'b1, 8'h00, 32'h3);
        repeat (60) @(posedge pclk);
        chk(tc[5], 1);
        chk(tc[31], 1);
        chk(tc[8] + tc[9], 2);
        chk(tc[1], 3);
        chk(ic[0] + ic[3], 2);
        chk(ic[1] + ic[2], 0);
        chk(alog.size(), 2);
        chk({16'h0, alog[0]}, 32'h1a);
        chk({16'h0, alog[1]}, 32'h123);
        chk(tc[2], 0);
        bus(1'b1, 8'h08, 32'h9);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h2);
        bus(1'b0, 8'h2c, 32'h0);
        chk(rd, 32'h0);
    endtask : t_run
    task automatic t_event;
        ev_idx <= 4'he;
        ev_go <= 1'b1;
        @(posedge pclk);
        ev_go <= 1'b0;
        poll_q(32'hf);
        chk(rd, 32'hf);
        chk(tc[2] + tc[3], 2);
        chk(tl[3] - tl[2], 5);
    endtask : t_event
    // Reads the queue pointer until it shows q; the caller judges the last read
    task automatic poll_q(input logic [31:0] q);
        rd = 32'hffff_ffff;
        for (int i = 0; i < 40 && rd !== q; i++) bus(1'b0, 8'h28, 32'h0);
    endtask : poll_q
    task automatic t_more;
        bus(1'b1, 8'h00, 32'h0);
        for (int i = 0; i < 5; i++) bus(1'b1, 8'(8'h38 + 4 * i), {16'h0, PROG2[i]});
        bus(1'b1, 8'h20, 32'h3);
        bus(1'b1, 8'h0c, 32'h1);
        bus(1'b1, 8'h28, 32'h0);
        bus(1'b1, 8'h00, 32'h3);
        poll_q(32'h5);
        chk(rd, 32'h5);
        chk(tl[7] - tl[6], 6);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h3);
        chk(tc[4], 0);
        ev_go <= 1'b1;
        @(posedge pclk);
        ev_go <= 1'b0;
        poll_q(32'h6);
        chk(rd, 32'h6);
        bus(1'b1, 8'h00, 32'h7);
        poll_q(32'h9);
        chk(rd, 32'h9);
        chk(tc[4], 2);
        bus(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0);
    endtask : t_more
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_load();
        t_run();
        t_event();
        t_more();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
